/* File: hdl/flt_pkg.sv */
// Summary of operation
// [R1] Bits 4 to 7 of overvoltage_log_enable_ch1_4 enable a capture on channels 1 to 4 overvoltage.
// [R2] Bits 0 to 3 of overvoltage_log_enable_ch5_12 enable a capture on channels 5 to 8 overvoltage.
// [R3] Bits 4 to 7 of overvoltage_log_enable_ch5_12 serve channels 9 to 12, twelve-channel part only.
// [R4] Bits 0 to 7 of early_warning_log_enable_ch1_8 enable capture on channels 1 to 8 early warning.
// [R5] Bits 0 to 3 of early_warning_log_enable_ch9_12 serve channels 9 to 12 and bits 7 to 4 are unused.
// [R6] Early warning fires in the configured direction, above or below, and a zero enable blocks it.
// [R7] A capture locks the log until software writes one to bit 1 of the unlock register.
// [R8] The two-bit log control selects flags and values, flags only, values only, or no logging.
// [R9] The undervoltage enable byte and bits 3 to 0 of the shared byte enable undervoltage capture.
// [R10] Any enabled condition requests a capture, and unused bits read zero and ignore writes.
`default_nettype none
package flt_pkg;
    // Register offsets on the configuration port
    localparam logic [7:0] FLT_ADDR_LOG_CTRL = 8'h47;
    localparam logic [7:0] FLT_ADDR_UV_LO    = 8'h48;
    localparam logic [7:0] FLT_ADDR_MIX      = 8'h49;
    localparam logic [7:0] FLT_ADDR_OV_HI    = 8'h4a;
    localparam logic [7:0] FLT_ADDR_EW_LO    = 8'h4b;
    localparam logic [7:0] FLT_ADDR_EW_HI    = 8'h4c;
    localparam logic [7:0] FLT_ADDR_UNLOCK   = 8'h5d;

    // Field positions
    localparam int FLT_UNLOCK_BIT = 1;
    localparam int FLT_LOCK_STAT_BIT = 0;

    // Log control encodings
    localparam logic [1:0] FLT_LOG_BOTH  = 2'h0;
    localparam logic [1:0] FLT_LOG_FLAGS = 2'h1;
    localparam logic [1:0] FLT_LOG_VALS  = 2'h2;
    localparam logic [1:0] FLT_LOG_OFF   = 2'h3;

    // Writable bit masks; upper-channel bits vanish on the eight-channel part
    localparam logic [7:0] FLT_MASK_LOG_CTRL = 8'h03;
    localparam logic [7:0] FLT_MASK_MIX_12   = 8'hff;
    localparam logic [7:0] FLT_MASK_MIX_8    = 8'hf0;
    localparam logic [7:0] FLT_MASK_OV_HI_12 = 8'hff;
    localparam logic [7:0] FLT_MASK_OV_HI_8  = 8'h0f;
    localparam logic [7:0] FLT_MASK_EW_HI_12 = 8'h0f;
    localparam logic [7:0] FLT_MASK_EW_HI_8  = 8'h00;
    localparam logic [11:0] FLT_CH_MASK_12   = 12'hfff;
    localparam logic [11:0] FLT_CH_MASK_8    = 12'h0ff;

    // Values after reset
    localparam logic [7:0] FLT_RST_REG  = 8'h00;
    localparam logic [1:0] FLT_RST_CTRL = 2'h0;

    // Comparator flags from the converter, one bit per channel
    typedef struct packed {
        logic [11:0] ov;
        logic [11:0] uv;
        logic [11:0] ew_above;
        logic [11:0] ew_below;
        logic [11:0] ew_sel_below;
    } flt_mon_flags_type;

    // Per-channel enables assembled from the registers
    typedef struct packed {
        logic [11:0] ov_en;
        logic [11:0] uv_en;
        logic [11:0] ew_en;
    } flt_enables_type;

    // Capture request toward the log writer
    typedef struct packed {
        logic        req;
        logic [1:0]  mode;
        logic [11:0] lines;
    } flt_capture_type;
endpackage
`default_nettype wire

/* File: hdl/flt_trig_match.sv */
`timescale 1ns/1ps
`default_nettype none
module flt_trig_match
    import flt_pkg::*;
(
    // Comparator flags and enables
    input  wire flt_mon_flags_type flags_i,
    input  wire flt_enables_type   en_i,
    input  wire logic [11:0]       ch_mask_i,
    // Per-channel hit
    output logic [11:0]            hit_o
);
    logic [11:0] ew_dir;

    // Early warning follows the direction chosen for the third limit
    assign ew_dir = (flags_i.ew_sel_below & flags_i.ew_below)
                  | (~flags_i.ew_sel_below & flags_i.ew_above); // R6

    // Zero enable suppresses; absent channels never hit
    assign hit_o = ch_mask_i & ((flags_i.ov & en_i.ov_en) // R1 R2 R3
                 | (flags_i.uv & en_i.uv_en)               // R9
                 | (ew_dir & en_i.ew_en));                 // R4 R5 R6
endmodule // flt_trig_match
`default_nettype wire

/* File: hdl/flt_log_trig.sv */
`timescale 1ns/1ps
`default_nettype none
module flt_log_trig
    import flt_pkg::*;
#(
    parameter bit TWELVE_CH = 1'b1
)(
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              resetn_i,
    // Configuration port
    input  wire logic [7:0]        cfg_addr_i,
    input  wire logic              cfg_wr_i,
    input  wire logic [7:0]        cfg_wdata_i,
    input  wire logic              cfg_rd_i,
    output logic [7:0]             cfg_rdata_o,
    // Comparator flags
    input  wire flt_mon_flags_type flags_i,
    // Log writer side
    output flt_capture_type        capture_o,
    output logic                   locked_o
);
    // Configuration registers and their next values
    logic [1:0]      log_ctrl_q;
    logic [1:0]      log_ctrl_d;
    logic [7:0]      uv_lo_q;
    logic [7:0]      uv_lo_d;
    logic [7:0]      mix_q;
    logic [7:0]      mix_d;
    logic [7:0]      ov_hi_q;
    logic [7:0]      ov_hi_d;
    logic [7:0]      ew_lo_q;
    logic [7:0]      ew_lo_d;
    logic [7:0]      ew_hi_q;
    logic [7:0]      ew_hi_d;

    // Lock, read data and capture record
    logic            locked_q;
    logic            locked_d;
    logic [7:0]      rdata_q;
    logic [7:0]      rdata_d;
    flt_capture_type cap_q;
    flt_capture_type cap_d;

    // Variant masks
    logic [7:0]      mask_mix;
    logic [7:0]      mask_ov_hi;
    logic [7:0]      mask_ew_hi;
    logic [11:0]     ch_mask;

    // Address selects
    logic            sel_ctrl;
    logic            sel_uv_lo;
    logic            sel_mix;
    logic            sel_ov_hi;
    logic            sel_ew_lo;
    logic            sel_ew_hi;
    logic            sel_unlock;

    // Write strobes
    logic            wr_ctrl;
    logic            wr_uv_lo;
    logic            wr_mix;
    logic            wr_ov_hi;
    logic            wr_ew_lo;
    logic            wr_ew_hi;
    logic            unlock_wr;

    // Composed read words
    logic [7:0]      rd_ctrl_word;
    logic [7:0]      rd_lock_word;

    // Trigger path
    logic [11:0]     hit;
    logic            fire;
    flt_enables_type en;

    // Variant masks: absent channels keep their bits at zero
    assign mask_mix   = TWELVE_CH ? FLT_MASK_MIX_12   : FLT_MASK_MIX_8;   // R3 R10
    assign mask_ov_hi = TWELVE_CH ? FLT_MASK_OV_HI_12 : FLT_MASK_OV_HI_8; // R3 R10
    assign mask_ew_hi = TWELVE_CH ? FLT_MASK_EW_HI_12 : FLT_MASK_EW_HI_8; // R5 R10
    assign ch_mask    = TWELVE_CH ? FLT_CH_MASK_12    : FLT_CH_MASK_8;

    // Address match; one helper so write and read paths can never disagree
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // Address selects shared by the write strobes and the read mux
    assign sel_ctrl   = addr_hit(cfg_addr_i, FLT_ADDR_LOG_CTRL);
    assign sel_uv_lo  = addr_hit(cfg_addr_i, FLT_ADDR_UV_LO);
    assign sel_mix    = addr_hit(cfg_addr_i, FLT_ADDR_MIX);
    assign sel_ov_hi  = addr_hit(cfg_addr_i, FLT_ADDR_OV_HI);
    assign sel_ew_lo  = addr_hit(cfg_addr_i, FLT_ADDR_EW_LO);
    assign sel_ew_hi  = addr_hit(cfg_addr_i, FLT_ADDR_EW_HI);
    assign sel_unlock = addr_hit(cfg_addr_i, FLT_ADDR_UNLOCK);

    // Write strobes; unmapped addresses match nothing and are dropped
    assign wr_ctrl   = cfg_wr_i && sel_ctrl;                              // R8
    assign wr_uv_lo  = cfg_wr_i && sel_uv_lo;                             // R9
    assign wr_mix    = cfg_wr_i && sel_mix;                               // R1
    assign wr_ov_hi  = cfg_wr_i && sel_ov_hi;                             // R2
    assign wr_ew_lo  = cfg_wr_i && sel_ew_lo;                             // R4
    assign wr_ew_hi  = cfg_wr_i && sel_ew_hi;                             // R5
    assign unlock_wr = cfg_wr_i && sel_unlock && cfg_wdata_i[FLT_UNLOCK_BIT]; // R7

    // Enables gathered per condition, channel 1 in bit 0
    assign en.ov_en = {ov_hi_q, mix_q[7:4]};                            // R1 R2 R3
    assign en.uv_en = {mix_q[3:0], uv_lo_q};                            // R9
    assign en.ew_en = {ew_hi_q[3:0], ew_lo_q};                          // R4 R5

    flt_trig_match u_match (
        .flags_i   (flags_i),
        .en_i      (en),
        .ch_mask_i (ch_mask),
        .hit_o     (hit)
    );

    // Any enabled hit captures once unless logging is off; lock then holds off further captures
    assign fire = (|hit) && !locked_q && (log_ctrl_q != FLT_LOG_OFF);   // R10 R8 R7

    // Capture sets lock and wins over an unlock in the same cycle
    assign locked_d = fire || (locked_q && !unlock_wr);                 // R7

    // Capture record: mode tells the writer what to store
    assign cap_d.req   = fire;
    assign cap_d.mode  = log_ctrl_q;                                    // R8
    assign cap_d.lines = fire ? hit : cap_q.lines;

    // Read words; the unlock bit is write-only and reads back low
    assign rd_ctrl_word = {6'h00, log_ctrl_q};                            // R10
    assign rd_lock_word = 8'(locked_q) << FLT_LOCK_STAT_BIT;              // R7

    // Read mux; unmapped addresses read zero, no strobe holds the last word
    assign rdata_d = !cfg_rd_i  ? rdata_q      :
                     sel_ctrl   ? rd_ctrl_word :
                     sel_uv_lo  ? uv_lo_q      :
                     sel_mix    ? mix_q        :
                     sel_ov_hi  ? ov_hi_q      :
                     sel_ew_lo  ? ew_lo_q      :
                     sel_ew_hi  ? ew_hi_q      :
                     sel_unlock ? rd_lock_word : 8'h00;                   // R10

    // Next values; masked bits are forced low so absent channels stay quiet
    assign log_ctrl_d = wr_ctrl  ? cfg_wdata_i[1:0]           : log_ctrl_q; // R8
    assign uv_lo_d    = wr_uv_lo ? cfg_wdata_i                : uv_lo_q;    // R9
    assign mix_d      = wr_mix   ? (cfg_wdata_i & mask_mix)   : mix_q;      // R1 R9
    assign ov_hi_d    = wr_ov_hi ? (cfg_wdata_i & mask_ov_hi) : ov_hi_q;    // R2 R3
    assign ew_lo_d    = wr_ew_lo ? cfg_wdata_i                : ew_lo_q;    // R4
    assign ew_hi_d    = wr_ew_hi ? (cfg_wdata_i & mask_ew_hi) : ew_hi_q;    // R5

    // Log control mode
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            log_ctrl_q <= FLT_RST_CTRL;
        end else begin
            log_ctrl_q <= log_ctrl_d;
        end
    end

    // Undervoltage enables, channels 1 to 8
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            uv_lo_q <= FLT_RST_REG;
        end else begin
            uv_lo_q <= uv_lo_d;
        end
    end

    // Shared byte: undervoltage upper channels, overvoltage lower channels
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            mix_q <= FLT_RST_REG;
        end else begin
            mix_q <= mix_d;
        end
    end

    // Overvoltage enables, upper channels
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ov_hi_q <= FLT_RST_REG;
        end else begin
            ov_hi_q <= ov_hi_d;
        end
    end

    // Early-warning enables, channels 1 to 8
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ew_lo_q <= FLT_RST_REG;
        end else begin
            ew_lo_q <= ew_lo_d;
        end
    end

    // Early-warning enables, upper channels
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ew_hi_q <= FLT_RST_REG;
        end else begin
            ew_hi_q <= ew_hi_d;
        end
    end

    // Log lock
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            locked_q <= 1'b0;
        end else begin
            locked_q <= locked_d;                                         // R7
        end
    end

    // Capture record; registered so the writer sees a clean one-cycle request
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            cap_q <= '0;
        end else begin
            cap_q <= cap_d;
        end
    end

    // Read data, held until the next read strobe
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs straight from the flops
    assign cfg_rdata_o = rdata_q;
    assign capture_o   = cap_q;
    assign locked_o    = locked_q;
endmodule // flt_log_trig
`default_nettype wire

/* File: sim/flt_log_trig_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module flt_log_trig_chk
    import flt_pkg::*;
#(parameter bit TWELVE_CH = 1'b1) (
    // Watched design ports
    input wire logic              sys_clk_i,
    input wire logic              resetn_i,
    input wire logic [7:0]        cfg_addr_i,
    input wire logic              cfg_wr_i,
    input wire logic [7:0]        cfg_wdata_i,
    input wire logic              cfg_rd_i,
    input wire logic [7:0]        cfg_rdata_o,
    input wire flt_mon_flags_type flags_i,
    input wire flt_capture_type   capture_o,
    input wire logic              locked_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // Shadow of log control, kept so refusals can be judged
    logic [1:0] ctrl_q;
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) ctrl_q <= FLT_RST_CTRL;
        else if (cfg_wr_i && cfg_addr_i == FLT_ADDR_LOG_CTRL) ctrl_q <= cfg_wdata_i[1:0];
    end
    // Address decode and any raised condition
    wire map_w = cfg_addr_i inside {[FLT_ADDR_LOG_CTRL:FLT_ADDR_EW_HI], FLT_ADDR_UNLOCK};
    wire any_w = |{flags_i.ov, flags_i.uv, flags_i.ew_above, flags_i.ew_below};
    sequence s_unlock;
        locked_o && cfg_wr_i && cfg_addr_i == FLT_ADDR_UNLOCK && cfg_wdata_i[FLT_UNLOCK_BIT];
    endsequence
    AST_REQ_PULSE: assert property (capture_o.req |=> !capture_o.req)
        else $error("long req");
    AST_REQ_LOCK: assert property (capture_o.req |-> locked_o)
        else $error("req without lock");
    AST_HELD: assert property (locked_o |=> !capture_o.req)
        else $error("req while locked");
    AST_UNLOCK: assert property (s_unlock |=> !locked_o)
        else $error("unlock ignored");
    AST_OFF: assert property (ctrl_q == FLT_LOG_OFF |=> !capture_o.req)
        else $error("req with logging off");
    AST_CTRL_RD: assert property (cfg_rd_i && cfg_addr_i == FLT_ADDR_LOG_CTRL
        |=> cfg_rdata_o == {6'h00, $past(ctrl_q)}) else $error("log control readback");
    AST_EW_HI: assert property (cfg_rd_i && cfg_addr_i == FLT_ADDR_EW_HI
        |=> (cfg_rdata_o & ~(TWELVE_CH ? FLT_MASK_EW_HI_12 : FLT_MASK_EW_HI_8)) == 8'h00)
        else $error("unused bits set");
    AST_UNMAP: assert property (cfg_rd_i && !map_w |=> cfg_rdata_o == 8'h00)
        else $error("unmapped read");
    AST_CAUSE: assert property (capture_o.req |-> $past(any_w) && !$past(locked_o))
        else $error("req without cause");
endmodule // flt_log_trig_chk
bind flt_log_trig flt_log_trig_chk #(.TWELVE_CH(TWELVE_CH)) u_chk (.sys_clk_i, .resetn_i,
    .cfg_addr_i, .cfg_wr_i, .cfg_wdata_i, .cfg_rd_i, .cfg_rdata_o, .flags_i, .capture_o,
    .locked_o);
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import flt_pkg::*;
    logic              sys_clk_i, resetn_i, cfg_wr_i, cfg_rd_i, locked_o;
    logic [7:0]        cfg_addr_i, cfg_wdata_i, cfg_rdata_o;
    flt_mon_flags_type flags_i;
    flt_capture_type   capture_o;
    logic [7:0]        rg [256];
    logic [11:0]       lines_exp;
    int                error_cnt, tests_run, cyc;
    flt_log_trig #(.TWELVE_CH(1'b1)) u_dut (.sys_clk_i, .resetn_i, .cfg_addr_i, .cfg_wr_i,
        .cfg_wdata_i, .cfg_rd_i, .cfg_rdata_o, .flags_i, .capture_o, .locked_o);
    // 10 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard, well above the few thousand cycles needed
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    // Writable bits per address; all else reads zero
    function automatic logic [7:0] msk(input logic [7:0] a);
        if (a == FLT_ADDR_LOG_CTRL) return FLT_MASK_LOG_CTRL;
        if (a == FLT_ADDR_EW_HI) return FLT_MASK_EW_HI_12;
        return (a inside {[FLT_ADDR_UV_LO:FLT_ADDR_EW_LO]}) ? 8'hff : 8'h00;
    endfunction
    // Channels expected to fire for a flag set
    function automatic logic [11:0] hits(input flt_mon_flags_type f);
        logic [11:0] ew;
        ew = (f.ew_below & f.ew_sel_below) | (f.ew_above & ~f.ew_sel_below);
        return (f.ov & {rg[8'h4a], rg[8'h49][7:4]}) | (f.uv & {rg[8'h49][3:0], rg[8'h48]})
            | (ew & {rg[8'h4c][3:0], rg[8'h4b]});
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        cfg_addr_i = a;
        cfg_wdata_i = d;
        cfg_wr_i = 1'b1;
        @(negedge sys_clk_i);
        cfg_wr_i = 1'b0;
        rg[a] = d & msk(a);
    endtask
    task automatic rdchk(input logic [7:0] a);
        @(negedge sys_clk_i);
        cfg_addr_i = a;
        cfg_rd_i = 1'b1;
        @(negedge sys_clk_i);
        cfg_rd_i = 1'b0;
        check("rdata", cfg_rdata_o, rg[a]);
    endtask
    // One pulse, lock holds it off, unlock lets a standing condition fire again
    task automatic trig(input flt_mon_flags_type f);
        logic [11:0] h;
        logic        fire;
        h = hits(f);
        fire = (h != 12'h000) && (rg[8'h47][1:0] != FLT_LOG_OFF);
        if (fire) lines_exp = h;
        @(negedge sys_clk_i);
        flags_i = f;
        @(negedge sys_clk_i);
        check("req", capture_o.req, fire);
        check("locked", locked_o, fire);
        check("lines", capture_o.lines, lines_exp);
        check("mode", capture_o.mode, rg[8'h47][1:0]);
        @(negedge sys_clk_i);
        check("req_locked", capture_o.req, 1'b0);
        wr(FLT_ADDR_UNLOCK, 8'h02);
        @(negedge sys_clk_i);
        check("refire", capture_o.req, fire);
        flags_i = '0;
        wr(FLT_ADDR_UNLOCK, 8'h02);
    endtask
    initial begin
        flt_mon_flags_type f;
        {cfg_addr_i, cfg_wdata_i, cfg_wr_i, cfg_rd_i, resetn_i} = '0;
        flags_i = '0;
        lines_exp = '0;
        rg = '{default: 8'h00};
        void'($urandom(32'hc267f5f7));
        repeat (2) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        for (int a = 8'h44; a < 8'h60; a++) rdchk(8'(a));
        $display("test reset_values done");
        // Every channel and kind alone, enables all set then all clear
        for (int p = 0; p < 2; p++) begin
            for (int a = 8'h48; a < 8'h4d; a++) wr(8'(a), (p == 0) ? 8'hff : 8'h00);
            for (int n = 0; n < 48; n++) begin
                f = flt_mon_flags_type'(60'h1 << (12 * (n / 12 + 1) + n % 12));
                f.ew_sel_below = (n < 12) ? 12'hfff : 12'h000;
                trig(f);
            end
        end
        $display("test single_channel done");
        for (int i = 0; i < 40; i++) begin
            for (int a = 8'h47; a < 8'h4e; a++) wr(8'(a), 8'($urandom()));
            for (int a = 8'h47; a < 8'h4e; a++) rdchk(8'(a));
            trig(flt_mon_flags_type'(60'({$urandom(), $urandom()})));
        end
        $display("test random done");
        conclude();
    end
endmodule // tb
`default_nettype wire
